// ---- hdl/irq_flags_pkg.sv ----
// Constants, types and state layout of the interrupt flag aggregation block
// Notes on behaviour
// - Read-only 16-bit identification register holds a fixed device code.
// - Bit 1 sets whenever any port ADC data register gets a new sample.
// - With 2^N averaging, a port's data refreshes only after 2^N conversions in single mode or 2^N sweeps in sweep modes.
// - Data refreshes per conversion in single mode, per sweep in sweep modes.
// - Bit 1 clears after flag read, then both ADC status reads.
// - Bit 2 sets when unread ADC data is overwritten; clears on flag read.
// - Bit 3 sets when a GPI port captures an event of its selected type.
// - Bits 3 and 4 clear after flag read, then both GPI status reads.
// - Bit 4 sets when GPI status is overwritten before the host read it.
// - Bit 5 sets when any DAC driver exceeds the overcurrent limit.
// - Bit 5 clears after flag read, then both overcurrent status reads.
// - Bit 8 sets above internal high limit; clears on flag read.
// - Bit 7 sets below internal low limit; clears on flag read.
// - Bit 6 sets on each new internal result; clears on flag read.
// - First external sensor flags sit in bits 11 to 9.
// - Bits 14:12 flag second sensor high, low, new result; clear on read.
// - Bit 15 sets while the port supply is low; clears on flag read.
// - ADC port status bit sets on each data load, regardless of mask.
// - GPI port events recorded in status bits regardless of mask.
// - Temperatures are 12-bit two's complement, compared signed to limits.
package irq_flags_pkg;

    localparam int NUM_PORTS   = 12;
    localparam int NUM_SENSORS = 3;
    localparam int TEMP_W      = 12;
    localparam int AVG_EXP_W   = 3;
    localparam int AVG_CNT_W   = 7;
    localparam int REG_W       = 16;

    // Temperature step in millidegrees per LSB
    localparam int TEMP_LSB_MILLIC = 125;

    // Identification code; the value is arbitrary
    localparam logic [REG_W-1:0] DEVICE_ID_DEFAULT = 16'hA5C3;

    // Flag register bit positions
    localparam int FLAG_ADC_EVENT   = 0;
    localparam int FLAG_ADC_READY   = 1;
    localparam int FLAG_ADC_MISSED  = 2;
    localparam int FLAG_GPI_READY   = 3;
    localparam int FLAG_GPI_MISSED  = 4;
    localparam int FLAG_DAC_OC      = 5;
    localparam int FLAG_TEMP_BASE   = 6;
    localparam int FLAG_SUPPLY_LOW  = 15;
    localparam int TEMP_FLAG_W      = 3;
    localparam int TEMP_HI_BIT      = 2;
    localparam int TEMP_LO_BIT      = 1;
    localparam int TEMP_NEW_BIT     = 0;

    // Bits that clear on a plain flag register read
    localparam logic [REG_W-1:0] FLAG_RC_MASK   = 16'hFFC5;
    localparam logic [REG_W-1:0] FLAG_RESET_VAL = 16'h0000;

    // Lower status register holds ports 10..0, upper one holds port 11
    localparam int ST_LO_W    = 11;
    localparam int ST_HI_PORT = 11;

    // Clear sequence groups
    localparam int GRP_ADC = 0;
    localparam int GRP_GPI = 1;
    localparam int GRP_DAC = 2;
    localparam int NUM_GRP = 3;

    typedef enum logic [2:0] {
        RD_DEVICE_ID = 3'h0,
        RD_FLAGS     = 3'h1,
        RD_ADC_ST_LO = 3'h2,
        RD_ADC_ST_HI = 3'h3,
        RD_GPI_ST_LO = 3'h4,
        RD_GPI_ST_HI = 3'h5,
        RD_DAC_ST_LO = 3'h6,
        RD_DAC_ST_HI = 3'h7
    } rdSel_t;

    typedef enum logic [1:0] {
        ADC_SINGLE_CONV  = 2'h0,
        ADC_SINGLE_SWEEP = 2'h1,
        ADC_CONT_SWEEP   = 2'h2,
        ADC_IDLE         = 2'h3
    } adcMode_t;

    typedef enum logic [1:0] {
        GPI_EDGE_NONE = 2'h0,
        GPI_EDGE_RISE = 2'h1,
        GPI_EDGE_FALL = 2'h2,
        GPI_EDGE_BOTH = 2'h3
    } gpiMode_t;

    typedef enum logic [3:0] {
        CLR_IDLE    = 4'h1,
        CLR_ARMED   = 4'h2,
        CLR_SEEN_LO = 4'h4,
        CLR_SEEN_HI = 4'h8
    } clrState_t;

    typedef struct packed {
        logic              valid;
        logic [TEMP_W-1:0] value;
        logic [TEMP_W-1:0] highLimit;
        logic [TEMP_W-1:0] lowLimit;
    } tempIn_t;

    typedef struct packed {
        logic                     rdStb;
        rdSel_t                   rdSel;
    } rdReq_t;

    typedef struct packed {
        logic [REG_W-1:0]                         rdData;
        logic [REG_W-1:0]                         flags;
        logic [NUM_PORTS-1:0]                     adc_port_status;
        logic [NUM_PORTS-1:0]                     gpi_port_status;
        logic [NUM_PORTS-1:0]                     dacSt;
        logic [NUM_PORTS-1:0]                     adcUnread;
        logic [NUM_PORTS-1:0]                     adcLoad;
        logic [NUM_PORTS-1:0][AVG_CNT_W-1:0]      avgCnt;
        clrState_t [NUM_GRP-1:0]                  clr;
        logic [NUM_PORTS-1:0]                     gpiS1;
        logic [NUM_PORTS-1:0]                     gpiS2;
        logic [NUM_PORTS-1:0]                     gpiPrev;
        logic [NUM_PORTS-1:0]                     ocS1;
        logic [NUM_PORTS-1:0]                     ocS2;
        logic                                     supS1;
        logic                                     supS2;
    } state_t;

endpackage

// ---- hdl/irq_flags.sv ----
// Interrupt flag aggregation: event capture, status registers, clear sequences
`timescale 1ns/1ps
module irq_flags
    import irq_flags_pkg::*;
#(
    parameter logic [REG_W-1:0] DEVICE_ID = DEVICE_ID_DEFAULT
) (
    // Clock and reset
    input  wire logic                                clk,
    input  wire logic                                rstn,
    // Register read access from the serial interface
    input  wire rdReq_t                              rdReq,
    output logic [REG_W-1:0]                         rdData,
    // ADC sequencing
    input  wire adcMode_t                            adcMode,
    input  wire logic [NUM_PORTS-1:0]                adcPortEn,
    input  wire logic [NUM_PORTS-1:0]                convDone,
    input  wire logic                                sweepDone,
    input  wire logic [NUM_PORTS-1:0][AVG_EXP_W-1:0] avgExp,
    input  wire logic [NUM_PORTS-1:0]                adcDataRead,
    input  wire logic                                adcFlagEvent,
    output logic [NUM_PORTS-1:0]                     adcLoad,
    // GPI ports
    input  wire logic [NUM_PORTS-1:0]                gpiIn,
    input  wire gpiMode_t [NUM_PORTS-1:0]            gpiMode,
    // DAC overcurrent comparators
    input  wire logic [NUM_PORTS-1:0]                dacOverCurrent,
    // Temperature sensors: internal, first external, second external
    input  wire tempIn_t [NUM_SENSORS-1:0]           tempIn,
    // High-voltage port supply monitor comparator
    input  wire logic                                supplyLow,
    // Flag register contents
    output logic [REG_W-1:0]                         intFlags
);

    state_t cur_ff;
    state_t nxt_st;

    // ------------------------------------------------------------
    // Per-port event decode
    // ------------------------------------------------------------
    logic [NUM_PORTS-1:0]                sampleTick;
    logic [NUM_PORTS-1:0]                loadNow;
    logic [NUM_PORTS-1:0][AVG_CNT_W-1:0] nxtAvgCnt;
    logic [NUM_PORTS-1:0]                gpiEvent;

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            logic [AVG_CNT_W-1:0] lastCnt;
            logic                 rise;
            logic                 fall;

            // mode tick: a conversion in single mode, a sweep of an enabled port in sweep modes, none when idle
            assign sampleTick[p] = (adcMode == ADC_SINGLE_CONV) ? convDone[p] :
                                   ((adcMode != ADC_IDLE) & sweepDone & adcPortEn[p]);

            assign lastCnt      = AVG_CNT_W'((8'h01 << avgExp[p]) - 8'h01);
            assign loadNow[p]   = sampleTick[p] & (cur_ff.avgCnt[p] >= lastCnt);
            assign nxtAvgCnt[p] = !sampleTick[p] ? cur_ff.avgCnt[p] :
                                  loadNow[p] ? '0 : cur_ff.avgCnt[p] + AVG_CNT_W'(1);

            assign rise = cur_ff.gpiS2[p] & ~cur_ff.gpiPrev[p];
            assign fall = ~cur_ff.gpiS2[p] & cur_ff.gpiPrev[p];
            always_comb begin
                case (gpiMode[p])
                    GPI_EDGE_RISE: gpiEvent[p] = rise;
                    GPI_EDGE_FALL: gpiEvent[p] = fall;
                    GPI_EDGE_BOTH: gpiEvent[p] = rise | fall;
                    default:       gpiEvent[p] = 1'b0;
                endcase
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Temperature comparisons
    // ------------------------------------------------------------
    logic [NUM_SENSORS-1:0][TEMP_FLAG_W-1:0] tempEvt;

    genvar s;
    generate
        for (s = 0; s < NUM_SENSORS; s++) begin : g_temp
            // signed compare of two's complement results
            assign tempEvt[s][TEMP_HI_BIT] = tempIn[s].valid &
                ($signed(tempIn[s].value) > $signed(tempIn[s].highLimit));
            assign tempEvt[s][TEMP_LO_BIT] = tempIn[s].valid &
                ($signed(tempIn[s].value) < $signed(tempIn[s].lowLimit));
            assign tempEvt[s][TEMP_NEW_BIT] = tempIn[s].valid;
        end
    endgenerate

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    logic                rdFlags;
    logic [NUM_GRP-1:0]  rdLo;
    logic [NUM_GRP-1:0]  rdHi;

    assign rdFlags     = rdReq.rdStb & (rdReq.rdSel == RD_FLAGS);
    assign rdLo[GRP_ADC] = rdReq.rdStb & (rdReq.rdSel == RD_ADC_ST_LO);
    assign rdHi[GRP_ADC] = rdReq.rdStb & (rdReq.rdSel == RD_ADC_ST_HI);
    assign rdLo[GRP_GPI] = rdReq.rdStb & (rdReq.rdSel == RD_GPI_ST_LO);
    assign rdHi[GRP_GPI] = rdReq.rdStb & (rdReq.rdSel == RD_GPI_ST_HI);
    assign rdLo[GRP_DAC] = rdReq.rdStb & (rdReq.rdSel == RD_DAC_ST_LO);
    assign rdHi[GRP_DAC] = rdReq.rdStb & (rdReq.rdSel == RD_DAC_ST_HI);

    // ------------------------------------------------------------
    // Clear sequences: flag read, then both status reads
    // ------------------------------------------------------------
    logic [NUM_GRP-1:0] seqDone;
    clrState_t [NUM_GRP-1:0] nxtClr;

    genvar g;
    generate
        for (g = 0; g < NUM_GRP; g++) begin : g_clr
            always_comb begin
                seqDone[g] = 1'b0;
                nxtClr[g]  = cur_ff.clr[g];
                if (rdFlags) begin
                    // A fresh flag read restarts the sequence
                    nxtClr[g] = CLR_ARMED;
                end else begin
                    case (cur_ff.clr[g])
                        CLR_IDLE: begin
                            nxtClr[g] = CLR_IDLE;
                        end
                        CLR_ARMED: begin
                            if (rdLo[g]) begin
                                nxtClr[g] = CLR_SEEN_LO;
                            end else if (rdHi[g]) begin
                                nxtClr[g] = CLR_SEEN_HI;
                            end
                        end
                        CLR_SEEN_LO: begin
                            if (rdHi[g]) begin
                                seqDone[g] = 1'b1;
                                nxtClr[g]  = CLR_IDLE;
                            end
                        end
                        CLR_SEEN_HI: begin
                            if (rdLo[g]) begin
                                seqDone[g] = 1'b1;
                                nxtClr[g]  = CLR_IDLE;
                            end
                        end
                        default: begin
                            nxtClr[g] = CLR_IDLE;
                        end
                    endcase
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic [NUM_PORTS-1:0] adcStClr;
    logic [NUM_PORTS-1:0] gpiStClr;
    logic [NUM_PORTS-1:0] dacStClr;
    logic [REG_W-1:0]     flagSet;
    logic [REG_W-1:0]     flagClr;

    always_comb begin
        nxt_st = cur_ff;

        // Synchronisers; first stage only feeds the second
        nxt_st.gpiS1   = gpiIn;
        nxt_st.gpiS2   = cur_ff.gpiS1;
        nxt_st.gpiPrev = cur_ff.gpiS2;
        nxt_st.ocS1    = dacOverCurrent;
        nxt_st.ocS2    = cur_ff.ocS1;
        nxt_st.supS1   = supplyLow;
        nxt_st.supS2   = cur_ff.supS1;

        nxt_st.avgCnt  = nxtAvgCnt;
        nxt_st.clr     = nxtClr;
        nxt_st.adcLoad = loadNow;

        adcStClr = {NUM_PORTS{seqDone[GRP_ADC]}};
        gpiStClr = {NUM_PORTS{seqDone[GRP_GPI]}};
        dacStClr = {NUM_PORTS{seqDone[GRP_DAC]}};

        // port status set on ADC load or GPI event, mask has no say; set wins
        nxt_st.adc_port_status = (cur_ff.adc_port_status & ~adcStClr) | loadNow;
        nxt_st.gpi_port_status = (cur_ff.gpi_port_status & ~gpiStClr) | gpiEvent;
        // overcurrent is a level; it re-sets while still present
        nxt_st.dacSt = (cur_ff.dacSt & ~dacStClr) | cur_ff.ocS2;

        // Host data reads mark a port's sample as consumed
        nxt_st.adcUnread = (cur_ff.adcUnread & ~adcDataRead) | loadNow;

        flagSet = '0;
        flagSet[FLAG_ADC_EVENT]  = adcFlagEvent;
        flagSet[FLAG_ADC_READY]  = |loadNow;
        flagSet[FLAG_ADC_MISSED] = |(loadNow & cur_ff.adcUnread & ~adcDataRead);
        flagSet[FLAG_GPI_READY]  = |gpiEvent;
        flagSet[FLAG_GPI_MISSED] = |(gpiEvent & cur_ff.gpi_port_status);
        flagSet[FLAG_DAC_OC]     = |cur_ff.ocS2;
        flagSet[FLAG_TEMP_BASE +: NUM_SENSORS*TEMP_FLAG_W] = tempEvt;
        flagSet[FLAG_SUPPLY_LOW] = cur_ff.supS2;

        flagClr = '0;
        if (rdFlags) begin
            flagClr = FLAG_RC_MASK;
        end
        // ready flag clears with the ADC sequence
        flagClr[FLAG_ADC_READY]  = seqDone[GRP_ADC];
        // both GPI flags clear with the GPI sequence
        flagClr[FLAG_GPI_READY]  = seqDone[GRP_GPI];
        flagClr[FLAG_GPI_MISSED] = seqDone[GRP_GPI];
        flagClr[FLAG_DAC_OC]     = seqDone[GRP_DAC];

        // An event in the clearing cycle survives to the next read
        nxt_st.flags = (cur_ff.flags & ~flagClr) | flagSet;

        // Read data shows the value before this read's clear
        if (rdReq.rdStb) begin
            case (rdReq.rdSel)
                RD_DEVICE_ID: nxt_st.rdData = DEVICE_ID;
                RD_FLAGS:     nxt_st.rdData = cur_ff.flags;
                RD_ADC_ST_LO: nxt_st.rdData = REG_W'(cur_ff.adc_port_status[ST_LO_W-1:0]);
                RD_ADC_ST_HI: nxt_st.rdData = REG_W'(cur_ff.adc_port_status[ST_HI_PORT]);
                RD_GPI_ST_LO: nxt_st.rdData = REG_W'(cur_ff.gpi_port_status[ST_LO_W-1:0]);
                RD_GPI_ST_HI: nxt_st.rdData = REG_W'(cur_ff.gpi_port_status[ST_HI_PORT]);
                RD_DAC_ST_LO: nxt_st.rdData = REG_W'(cur_ff.dacSt[ST_LO_W-1:0]);
                RD_DAC_ST_HI: nxt_st.rdData = REG_W'(cur_ff.dacSt[ST_HI_PORT]);
                default:      nxt_st.rdData = '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cur_ff        <= '0;
            cur_ff.flags  <= FLAG_RESET_VAL;
            cur_ff.clr    <= '{default: CLR_IDLE};
        end else begin
            cur_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdData   = cur_ff.rdData;
    assign intFlags = cur_ff.flags;
    assign adcLoad  = cur_ff.adcLoad;

endmodule

// ---- dv/irq_flags_properties.sv ----
// Concurrent checks on the flag aggregation block ports
`timescale 1ns/1ps
module irq_flags_checker
    import irq_flags_pkg::*;
#(
    parameter logic [REG_W-1:0] DEVICE_ID = DEVICE_ID_DEFAULT
) (
    input  wire logic                      clk,
    input  wire logic                      rstn,
    input  wire rdReq_t                    rdReq,
    input  wire logic [REG_W-1:0]          rdData,
    input  wire logic                      adcFlagEvent,
    input  wire logic [NUM_PORTS-1:0]      adcLoad,
    input  wire tempIn_t [NUM_SENSORS-1:0] tempIn,
    input  wire logic                      supplyLow,
    input  wire logic [REG_W-1:0]          intFlags
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_reset_clears: assert property (disable iff (1'b0)
        !rstn |=> intFlags == FLAG_RESET_VAL && rdData == 16'h0000)
        else $error("outputs not cleared by reset");
    a_ident_read: assert property (
        rdReq.rdStb && rdReq.rdSel == RD_DEVICE_ID |=> rdData == DEVICE_ID)
        else $error("identification read wrong");
    a_flag_read_data: assert property (
        rdReq.rdStb && rdReq.rdSel == RD_FLAGS |=> rdData == $past(intFlags))
        else $error("flag read data wrong");
    a_ready_with_load: assert property (adcLoad != '0 |-> intFlags[FLAG_ADC_READY])
        else $error("ready flag missing at load");
    a_ready_clear_path: assert property ($fell(intFlags[FLAG_ADC_READY]) |->
        $past(rdReq.rdStb) && $past(rdReq.rdSel) inside {RD_ADC_ST_LO, RD_ADC_ST_HI})
        else $error("ready flag cleared without status read");
    a_gpi_clear_path: assert property ($fell(intFlags[FLAG_GPI_READY]) |->
        $past(rdReq.rdStb) && $past(rdReq.rdSel) inside {RD_GPI_ST_LO, RD_GPI_ST_HI})
        else $error("event flag cleared without status read");
    a_event_bit: assert property (adcFlagEvent |=> intFlags[FLAG_ADC_EVENT])
        else $error("general event flag not set");
    a_temp_new: assert property (tempIn[0].valid |=> intFlags[FLAG_TEMP_BASE])
        else $error("new result flag not set");
    a_ext2_high: assert property (tempIn[2].valid &&
        $signed(tempIn[2].value) > $signed(tempIn[2].highLimit) |=> intFlags[14])
        else $error("second sensor high flag not set");
    a_ext1_read_clear: assert property (
        rdReq.rdStb && rdReq.rdSel == RD_FLAGS && !tempIn[1].valid |=> intFlags[11:9] == 3'h0)
        else $error("first sensor flags not cleared by read");
    a_supply_low: assert property (supplyLow [*3] |=> intFlags[FLAG_SUPPLY_LOW])
        else $error("supply low flag not set");
endmodule

bind irq_flags irq_flags_checker #(.DEVICE_ID(DEVICE_ID)) u_checker (
    .clk(clk), .rstn(rstn), .rdReq(rdReq), .rdData(rdData), .adcFlagEvent(adcFlagEvent),
    .adcLoad(adcLoad), .tempIn(tempIn), .supplyLow(supplyLow), .intFlags(intFlags));

// ---- dv/host_reader.sv ----
// Host model issuing register reads over the serial side
`timescale 1ns/1ps
module host_reader
    import irq_flags_pkg::*;
(
    // Clock
    input  wire logic             clk,
    // Read port
    input  wire logic [REG_W-1:0] rdData,
    output rdReq_t                rdReq
);
    initial rdReq = '{rdStb: 1'b0, rdSel: RD_DEVICE_ID};

    // One strobe cycle, data taken after the answering edge
    task automatic readReg(input rdSel_t sel, output logic [REG_W-1:0] d);
        @(posedge clk);
        rdReq <= '{rdStb: 1'b1, rdSel: sel};
        @(posedge clk);
        rdReq.rdStb <= 1'b0;
        #1 d = rdData;
    endtask

    function automatic logic gpiMissedUsable(input logic [REG_W-1:0] f);
        return f[FLAG_GPI_MISSED] && f[FLAG_GPI_READY];
    endfunction
endmodule

// ---- dv/irq_flags_test.sv ----
// Self-checking testbench of the interrupt flag aggregation block
`timescale 1ns/1ps
module irq_flags_test
    import irq_flags_pkg::*;
();
    logic clk, rstn, sweepDone, adcFlagEvent, supplyLow;
    logic [REG_W-1:0] rdData, intFlags, d;
    logic [NUM_PORTS-1:0] adcPortEn, convDone, adcDataRead, adcLoad, gpiIn, dacOverCurrent;
    logic [NUM_PORTS-1:0][AVG_EXP_W-1:0] avgExp;
    gpiMode_t [NUM_PORTS-1:0] gpiMode;
    tempIn_t [NUM_SENSORS-1:0] tempIn;
    adcMode_t adcMode;
    rdReq_t rdReq;
    int miscompares = 0;
    int checksDone = 0;

    host_reader HOST (.clk(clk), .rdData(rdData), .rdReq(rdReq));
    irq_flags DUT (.clk(clk), .rstn(rstn), .rdReq(rdReq), .rdData(rdData), .adcMode(adcMode),
        .adcPortEn(adcPortEn), .convDone(convDone), .sweepDone(sweepDone), .avgExp(avgExp),
        .adcDataRead(adcDataRead), .adcFlagEvent(adcFlagEvent), .adcLoad(adcLoad),
        .gpiIn(gpiIn), .gpiMode(gpiMode), .dacOverCurrent(dacOverCurrent), .tempIn(tempIn),
        .supplyLow(supplyLow), .intFlags(intFlags));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checksDone++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Bounded wait for a flag bit, synchronisers give a few cycles of lag
    // Looked at 1 ns after each edge so the flag has settled
    task automatic waitFlag(input int b);
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            #1;
            if (intFlags[b] === 1'b1) break;
        end
    endtask

    task automatic tick(input logic sweep, input logic [11:0] conv);
        @(posedge clk);
        sweepDone <= sweep;
        convDone <= conv;
        @(posedge clk);
        sweepDone <= 1'b0;
        convDone <= 12'h000;
        #1;
    endtask

    task automatic t_ident();
        #1 cmp(intFlags, FLAG_RESET_VAL);
        HOST.readReg(RD_DEVICE_ID, d);
        cmp(d, DEVICE_ID_DEFAULT);
        $display("ident test done");
    endtask

    task automatic t_temp();
        int b;
        for (int s = 0; s < NUM_SENSORS; s++) begin
            b = FLAG_TEMP_BASE + TEMP_FLAG_W * s;
            @(posedge clk);
            tempIn[s].value <= 12'h100;
            tempIn[s].valid <= 1'b1;
            @(posedge clk);
            tempIn[s].valid <= 1'b0;
            #1 cmp(intFlags, 16'h0005 << b);
            HOST.readReg(RD_FLAGS, d);
            cmp(d, 16'h0005 << b);
            cmp(intFlags, 16'h0000);
            // Negative value must not pass as large
            @(posedge clk);
            tempIn[s].value <= 12'hF00;
            tempIn[s].valid <= 1'b1;
            @(posedge clk);
            tempIn[s].valid <= 1'b0;
            #1 cmp(intFlags, 16'h0003 << b);
            HOST.readReg(RD_FLAGS, d);
        end
        $display("temperature test done");
    endtask

    task automatic t_adc();
        @(posedge clk);
        adcMode <= ADC_SINGLE_CONV;
        adcPortEn <= 12'h808;
        tick(1'b0, 12'h008);
        cmp({4'h0, adcLoad}, 16'h0008);
        cmp(intFlags, 16'h0002);
        tick(1'b0, 12'h008);
        cmp(intFlags, 16'h0006);
        HOST.readReg(RD_FLAGS, d);
        cmp(intFlags, 16'h0002);
        HOST.readReg(RD_ADC_ST_LO, d);
        cmp(d, 16'h0008);
        cmp(intFlags, 16'h0002);
        HOST.readReg(RD_ADC_ST_HI, d);
        cmp(intFlags, 16'h0000);
        @(posedge clk);
        adcMode <= ADC_CONT_SWEEP;
        avgExp <= {NUM_PORTS{3'h2}};
        repeat (3) begin
            tick(1'b1, 12'h000);
            cmp({4'h0, adcLoad}, 16'h0000);
        end
        tick(1'b1, 12'h000);
        cmp({4'h0, adcLoad}, 16'h0808);
        @(posedge clk);
        adcMode <= ADC_IDLE;
        HOST.readReg(RD_FLAGS, d);
        HOST.readReg(RD_ADC_ST_HI, d);
        cmp(d, 16'h0001);
        HOST.readReg(RD_ADC_ST_LO, d);
        cmp(intFlags, 16'h0000);
        // Data read in time keeps the missed flag clear
        @(posedge clk);
        adcMode <= ADC_SINGLE_SWEEP;
        avgExp <= '0;
        adcDataRead <= 12'h808;
        @(posedge clk);
        adcDataRead <= 12'h000;
        tick(1'b1, 12'h000);
        cmp({4'h0, adcLoad}, 16'h0808);
        cmp(intFlags, 16'h0002);
        tick(1'b1, 12'h000);
        cmp(intFlags, 16'h0006);
        HOST.readReg(RD_FLAGS, d);
        HOST.readReg(RD_ADC_ST_LO, d);
        HOST.readReg(RD_ADC_ST_HI, d);
        cmp(intFlags, 16'h0000);
        $display("adc test done");
    endtask

    task automatic t_gpi();
        @(posedge clk);
        gpiIn <= 12'h020;
        waitFlag(FLAG_GPI_READY);
        cmp(intFlags, 16'h0008);
        @(posedge clk);
        gpiIn <= 12'h000;
        repeat (4) @(posedge clk);
        gpiIn <= 12'h020;
        waitFlag(FLAG_GPI_MISSED);
        cmp({15'h0, HOST.gpiMissedUsable(intFlags)}, 16'h0001);
        HOST.readReg(RD_FLAGS, d);
        cmp(intFlags, 16'h0018);
        HOST.readReg(RD_GPI_ST_LO, d);
        cmp(d, 16'h0020);
        cmp(intFlags, 16'h0018);
        HOST.readReg(RD_GPI_ST_HI, d);
        cmp(intFlags, 16'h0000);
        // Falling edge counts once the port selects it
        @(posedge clk);
        gpiMode[5] <= GPI_EDGE_FALL;
        gpiIn <= 12'h000;
        waitFlag(FLAG_GPI_READY);
        cmp(intFlags, 16'h0008);
        HOST.readReg(RD_FLAGS, d);
        HOST.readReg(RD_GPI_ST_HI, d);
        HOST.readReg(RD_GPI_ST_LO, d);
        cmp(d, 16'h0020);
        cmp(intFlags, 16'h0000);
        $display("gpi test done");
    endtask

    task automatic t_dac_supply();
        @(posedge clk);
        dacOverCurrent <= 12'h800;
        supplyLow <= 1'b1;
        adcFlagEvent <= 1'b1;
        @(posedge clk);
        adcFlagEvent <= 1'b0;
        waitFlag(FLAG_SUPPLY_LOW);
        @(posedge clk);
        dacOverCurrent <= 12'h000;
        supplyLow <= 1'b0;
        repeat (4) @(posedge clk);
        #1 cmp(intFlags, 16'h8021);
        HOST.readReg(RD_FLAGS, d);
        cmp(intFlags, 16'h0020);
        HOST.readReg(RD_DAC_ST_HI, d);
        cmp(d, 16'h0001);
        HOST.readReg(RD_DAC_ST_LO, d);
        cmp(d, 16'h0000);
        cmp(intFlags, 16'h0000);
        $display("overcurrent and supply test done");
    endtask

    // Reset in mid-run beats a pending event and clears read data
    task automatic t_reset();
        HOST.readReg(RD_DEVICE_ID, d);
        @(posedge clk);
        adcFlagEvent <= 1'b1;
        rstn <= 1'b0;
        @(posedge clk);
        adcFlagEvent <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        #1 cmp(intFlags, FLAG_RESET_VAL);
        cmp(rdData, 16'h0000);
        HOST.readReg(RD_DEVICE_ID, d);
        cmp(d, DEVICE_ID_DEFAULT);
        $display("reset test done");
    endtask

    initial begin
        rstn = 1'b0;
        adcMode = ADC_IDLE;
        {sweepDone, adcFlagEvent, supplyLow} = 3'h0;
        {adcPortEn, convDone, adcDataRead, gpiIn, dacOverCurrent} = '0;
        avgExp = '0;
        for (int i = 0; i < NUM_PORTS; i++) gpiMode[i] = GPI_EDGE_RISE;
        for (int s = 0; s < NUM_SENSORS; s++) begin
            tempIn[s] = '{valid: 1'b0, value: 12'h000, highLimit: 12'h080, lowLimit: 12'h010};
        end
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        t_ident();
        t_temp();
        t_adc();
        t_gpi();
        t_dac_supply();
        t_reset();
        conclude();
    end

    // Whole run needs under two hundred cycles
    initial begin
        #(5000 * 25);
        miscompares++;
        conclude();
    end
endmodule
